// file: core/wcnm_pkg.sv
// Package for the wiper code and nonvolatile map block
package wcnm_pkg;
  localparam int WCNM_ADDR_W = 4;         // Store address width
  localparam int WCNM_DATA_W = 8;         // One byte per location
  localparam int WCNM_TAPS = 256;         // Tap switches per channel
  localparam int WCNM_LOCS = 16;          // Store locations
  localparam logic [3:0] WCNM_ADDR_SAVED_CH1 = 4'h0; // saved_wiper_ch1
  localparam logic [3:0] WCNM_ADDR_SAVED_CH2 = 4'h1; // saved_wiper_ch2
  localparam logic [3:0] WCNM_ADDR_USER_FIRST = 4'h2; // user_byte_1
  localparam logic [3:0] WCNM_ADDR_USER_LAST = 4'hF;  // user_byte_14
  localparam logic [3:0] WCNM_ADDR_WIPER_CH1 = 4'h0;  // wiper_register_ch1
  localparam logic [3:0] WCNM_ADDR_WIPER_CH2 = 4'h1;  // wiper_register_ch2
  localparam logic [7:0] WCNM_CODE_ZERO = 8'h00;  // Zero scale
  localparam logic [7:0] WCNM_CODE_ONE = 8'h01;   // One step
  localparam logic [7:0] WCNM_CODE_MID = 8'h80;   // Midscale
  localparam logic [7:0] WCNM_CODE_FULL = 8'hFF;  // Full scale
  localparam logic [7:0] WCNM_RESET_BYTE = 8'h00; // Reset contents of wiper, output and readback bytes; the store is not reset
  // Instruction codes
  localparam logic [3:0] WCNM_OP_NOP = 4'h0;
  localparam logic [3:0] WCNM_OP_RESTORE_READ = 4'h1;
  localparam logic [3:0] WCNM_OP_SAVE = 4'h2;
  localparam logic [3:0] WCNM_OP_STORE_USER = 4'h3;
  localparam logic [3:0] WCNM_OP_DEC6_ONE = 4'h4;
  localparam logic [3:0] WCNM_OP_DEC6_ALL = 4'h5;
  localparam logic [3:0] WCNM_OP_DEC_ONE = 4'h6;
  localparam logic [3:0] WCNM_OP_DEC_ALL = 4'h7;
  localparam logic [3:0] WCNM_OP_RESTORE = 4'h8;
  localparam logic [3:0] WCNM_OP_READ_STORE = 4'h9;
  localparam logic [3:0] WCNM_OP_READ_WIPER = 4'hA;
  localparam logic [3:0] WCNM_OP_WRITE_WIPER = 4'hB;
  localparam logic [3:0] WCNM_OP_INC6_ONE = 4'hC;
  localparam logic [3:0] WCNM_OP_INC6_ALL = 4'hD;
  localparam logic [3:0] WCNM_OP_INC_ONE = 4'hE;
  localparam logic [3:0] WCNM_OP_INC_ALL = 4'hF;
  // Serial frame as latched at chip select rise
  typedef struct packed {
    logic [3:0] op;    // Instruction code
    logic [3:0] addr;  // Address field, channel_select_bit in bit 0
    logic [7:0] data;  // Data byte 0
  } wcnm_frame_t;
  // Tap selection of both channels
  typedef struct packed {
    logic [255:0] ch2; // One-hot taps channel 2
    logic [255:0] ch1; // One-hot taps channel 1
  } wcnm_taps_t;
endpackage

// file: core/wcnm_core.sv
// Wiper code and nonvolatile map core with serial link front end
`timescale 1ns/100ps

module wcnm_core
  import wcnm_pkg::*;
(
  input wire logic clk_in,            // System clock
  input wire logic reset_n_in,        // Synchronous reset, active low
  input wire logic clk_en_in,         // Clock enable, freezes clk_in domain state when low
  input wire logic link_sclk_in,      // Serial clock from the controller
  input wire logic link_cs_n_in,      // Chip select, active low
  input wire logic link_sdi_in,       // Serial data in
  output logic link_sdo_out,          // Serial data out
  output wcnm_taps_t taps_out,        // One-hot tap switches
  output logic end_switch_a_out,      // Terminal A end switch
  output logic end_switch_b_out,      // Terminal B end switch
  output logic read_mode_out,         // Read-mode power state
  output logic [7:0] wiper_ch1_out,   // wiper_register_ch1
  output logic [7:0] wiper_ch2_out    // wiper_register_ch2
);

  // Crossing scheme between the two clocks:
  // - The frame register is only read while chip select is high, when the
  //   serial clock no longer samples, so it is quasi-static for clk_in.
  // - Chip select enters clk_in through three flops; a level counts once
  //   the second and third flop agree, which filters a glitchy edge.
  // - Readback bytes go back as a held byte plus an event toggle; the link
  //   side takes the byte only after the toggle has passed two flops.
  // - The serial clock may stop between frames, so the controller must
  //   give it a few edges before a frame that is to carry a readback.

  // ---- System domain state shared with the link side ----
  logic [2:0] cs_sync;      // cs_sync[0] read only by cs_sync[1]
  logic cs_prev;            // Agreed chip select level
  logic load_toggle;        // Event toggle for reply load
  logic [7:0] reply_byte;   // Byte held for readback
  logic power_on_done;      // Power-on restore done

  // ---- Link domain: shift register clocked by the serial clock ----
  logic [15:0] link_shift;      // Incoming frame bits
  logic [15:0] link_out_shift;  // Outgoing frame bits
  logic link_cs_d = 1'b1;       // Chip select seen at last falling edge
  logic [1:0] link_load_sync;   // Load toggle brought into link domain
  logic link_load_seen = 1'b0;  // Last load toggle taken
  logic [15:0] link_reply;      // Stored readback word
  logic link_use_reply;         // Reply valid for the current frame
  logic link_reply_used = 1'b0; // Reply toggle consumed at frame start
  logic [3:0] out_idx;          // Bit index during a reply frame
  // No reset exists in this domain; these start values make the first frames clean
  wire link_frame_start = link_cs_d && !link_cs_n_in; // First falling edge of a frame
  wire link_reply_fresh = (link_load_seen != link_reply_used); // Unsent reply waits

  // Samples SDI on rising edge while selected
  always_ff @(posedge link_sclk_in) begin
    if (!link_cs_n_in) begin
      link_shift <= {link_shift[14:0], link_sdi_in};
    end
  end

  // Load toggle crossing, first stage read only by second
  always_ff @(posedge link_sclk_in) begin
    link_load_sync <= {link_load_sync[0], load_toggle};
  end

  // Output register shifts on falling edge; echo of the last frame loaded at frame start
  always_ff @(negedge link_sclk_in) begin
    link_cs_d <= link_cs_n_in;
    if (link_cs_d && !link_cs_n_in) begin
      link_out_shift <= {link_shift[14:0], 1'b0};
    end else if (!link_cs_n_in) begin
      link_out_shift <= {link_out_shift[14:0], 1'b0};
    end
  end

  // Reply replaces the echo when a readback is pending
  always_ff @(posedge link_sclk_in) begin
    if (link_load_sync[1] != link_load_seen) begin
      link_load_seen <= link_load_sync[1];
      link_reply <= {8'h00, reply_byte};
    end
  end

  // ---- System domain: chip select synchroniser, three flops ----

  wire cs_agree = (cs_sync[2] == cs_sync[1]);
  wire cs_rise = cs_agree && cs_sync[1] && !cs_prev;
  // Frame stable in link domain once chip select is high
  wire wcnm_frame_t frame = link_shift;
  wire [3:0] op = frame.op;
  wire [3:0] addr = frame.addr;
  wire sel_ch2 = addr[0];   // channel_select_bit

  // Store memory, one byte per location
  logic [7:0] store [WCNM_LOCS];
  logic [7:0] wiper [2];

  // Shifts
  function automatic logic [7:0] shift_left6(input logic [7:0] code);
    if (code == WCNM_CODE_ZERO) begin
      shift_left6 = WCNM_CODE_ONE;
    end else if (code >= WCNM_CODE_MID) begin
      shift_left6 = WCNM_CODE_FULL;
    end else begin
      shift_left6 = {code[6:0], 1'b0};
    end
  endfunction

  function automatic logic [7:0] shift_right6(input logic [7:0] code);
    shift_right6 = {1'b0, code[7:1]};
  endfunction

  function automatic logic [7:0] step(input logic [7:0] code, input logic up);
    if (up) begin
      step = (code == WCNM_CODE_FULL) ? code : code + 8'h01;
    end else begin
      step = (code == WCNM_CODE_ZERO) ? code : code - 8'h01;
    end
  endfunction

  // Chip select synchroniser
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      cs_sync <= 3'h7;
      cs_prev <= 1'b1;
    end else if (clk_en_in) begin
      cs_sync <= {cs_sync[1:0], link_cs_n_in};
      if (cs_agree) begin
        cs_prev <= cs_sync[1];
      end
    end
  end

  // Store writes; store keeps contents across reset
  // A save copies the addressed wiper, a user store takes data byte 0
  always_ff @(posedge clk_in) begin
    if (clk_en_in && reset_n_in && cs_rise) begin
      if (op == WCNM_OP_SAVE) begin
        store[{3'h0, sel_ch2}] <= wiper[sel_ch2];
      end
      if (op == WCNM_OP_STORE_USER) begin
        store[addr] <= frame.data;
      end
    end
  end

  // Next code of one channel for the instruction in the frame
  // Codes not listed keep the wiper where it is
  function automatic logic [7:0] exec_code(input logic [3:0] opc, input logic hit,
      input logic [7:0] saved, input logic [7:0] code, input logic [7:0] data);
    exec_code = code; // Hold by default
    unique case (opc)
      WCNM_OP_RESTORE_READ, WCNM_OP_RESTORE: begin
        exec_code = saved;
      end
      WCNM_OP_WRITE_WIPER: begin
        exec_code = hit ? data : code;
      end
      WCNM_OP_DEC6_ONE: begin
        exec_code = hit ? shift_right6(code) : code;
      end
      WCNM_OP_DEC6_ALL: begin
        exec_code = shift_right6(code);
      end
      WCNM_OP_INC6_ONE: begin
        exec_code = hit ? shift_left6(code) : code;
      end
      WCNM_OP_INC6_ALL: begin
        exec_code = shift_left6(code);
      end
      WCNM_OP_DEC_ONE: begin
        exec_code = hit ? step(code, 1'b0) : code;
      end
      WCNM_OP_DEC_ALL: begin
        exec_code = step(code, 1'b0);
      end
      WCNM_OP_INC_ONE: begin
        exec_code = hit ? step(code, 1'b1) : code;
      end
      WCNM_OP_INC_ALL: begin
        exec_code = step(code, 1'b1);
      end
      default: begin
        exec_code = code; // Store and read instructions leave wipers alone
      end
    endcase
  endfunction

  // One-hot tap decode, code 0 nearest terminal B
  function automatic logic [255:0] tap_decode(input logic [7:0] code);
    tap_decode = 256'h1 << code;
  endfunction

  // Per-channel next code, channel_select_bit picks the addressed one
  wire [7:0] next_wiper [2]; // Code taken at execution
  generate
    for (genvar ch = 0; ch < 2; ch++) begin : g_ch
      wire hit = (sel_ch2 == 1'(ch));
      assign next_wiper[ch] = exec_code(op, hit, store[ch], wiper[ch], frame.data);
    end
  endgenerate

  // Wiper registers. The first enabled edge after reset copies the saved
  // codes in; the store itself is never reset, so a device that was never
  // saved comes up with unknown wipers until a code is written.
  // Execution happens once per agreed chip select rise.
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      wiper[0] <= WCNM_RESET_BYTE;
      wiper[1] <= WCNM_RESET_BYTE;
    end else if (clk_en_in) begin
      if (!power_on_done) begin
        wiper[0] <= store[0];
        wiper[1] <= store[1];
      end else if (cs_rise) begin
        wiper[0] <= next_wiper[0];
        wiper[1] <= next_wiper[1];
      end
    end
  end

  // Tap selection registers, updated together with the wiper outputs
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      taps_out <= {256'h1, 256'h1};
    end else if (clk_en_in) begin
      taps_out.ch1 <= tap_decode(wiper[0]);
      taps_out.ch2 <= tap_decode(wiper[1]);
    end
  end

  // Readback, read-mode state and power-on flag
  // A readback byte is held until the next read; the toggle tells the
  // link side that a fresh byte waits for the following frame
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      power_on_done <= 1'b0;
      read_mode_out <= 1'b0;
      load_toggle <= 1'b0;
      reply_byte <= WCNM_RESET_BYTE;
    end else if (clk_en_in) begin
      power_on_done <= 1'b1;
      if (cs_rise) begin
        if (op == WCNM_OP_RESTORE_READ) begin
          read_mode_out <= 1'b1;
        end else if (op == WCNM_OP_NOP) begin
          read_mode_out <= 1'b0;
        end
        if (op == WCNM_OP_READ_STORE) begin
          reply_byte <= store[addr];
          load_toggle <= ~load_toggle;
        end else if (op == WCNM_OP_READ_WIPER) begin
          reply_byte <= wiper[sel_ch2];
          load_toggle <= ~load_toggle;
        end
      end
    end
  end

  // Registered outputs
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      end_switch_a_out <= 1'b0;
      end_switch_b_out <= 1'b0;
      wiper_ch1_out <= WCNM_RESET_BYTE;
      wiper_ch2_out <= WCNM_RESET_BYTE;
    end else if (clk_en_in) begin
      end_switch_a_out <= 1'b1;
      end_switch_b_out <= 1'b1;
      wiper_ch1_out <= wiper[0];
      wiper_ch2_out <= wiper[1];
    end
  end

  // Serial out: reply word after a read, otherwise echo of the last frame
  // The first bit leaves on the first falling edge with select low, so the
  // controller needs one falling edge before its first sampling edge.
  // A reply is sent once; later frames fall back to the echo.
  always_ff @(negedge link_sclk_in) begin
    if (link_frame_start) begin
      link_use_reply <= link_reply_fresh;
      link_reply_used <= link_load_seen;
      link_sdo_out <= link_reply_fresh ? link_reply[15] : link_shift[15];
    end else begin
      link_sdo_out <= link_use_reply ? link_reply[15 - out_idx] : link_out_shift[15];
    end
  end

  // Bit index during a reply frame
  always_ff @(negedge link_sclk_in) begin
    out_idx <= link_frame_start ? 4'h1 : out_idx + 4'h1;
  end

endmodule

// file: verif/wcnm_core_monitor.sv
// Port checker for the wiper code core
`timescale 1ns/100ps
module wcnm_core_monitor
  import wcnm_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic link_cs_n_in,
  input wire wcnm_taps_t taps_out,
  input wire logic end_switch_a_out,
  input wire logic end_switch_b_out,
  input wire logic read_mode_out,
  input wire logic [7:0] wiper_ch1_out,
  input wire logic [7:0] wiper_ch2_out
);
  logic cs_q; // Chip select one cycle back
  logic [1:0] rises; // Frames seen, saturating
  logic [3:0] since_rise; // Cycles since chip select rose
  logic [3:0] settle; // Wait until both wipers hold known codes
  wire cs_rise = link_cs_n_in && !cs_q;
  wire armed = (settle == 4'hF);
  wire [3:0] next_since = cs_rise ? 4'h0 : since_rise + {3'h0, since_rise != 4'hF};
  wire [1:0] next_rises = rises + {1'b0, cs_rise && rises != 2'h3};
  wire [3:0] next_settle = settle + {3'h0, rises == 2'h3 && settle != 4'hF};
  // Counter registers
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      cs_q <= 1'b1;
      rises <= 2'h0;
      since_rise <= 4'hF;
      settle <= 4'h0;
    end else begin
      cs_q <= link_cs_n_in;
      rises <= next_rises;
      since_rise <= next_since;
      settle <= next_settle;
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  // Changes only shortly after a frame closes
  sequence soon_after_cs;
    since_rise inside {[1:8]};
  endsequence
  ends_on_a: assert property ($past(reset_n_in) |-> end_switch_a_out && end_switch_b_out)
    else $error("end switch off");
  rst_tap_a: assert property (disable iff (1'b0) $past(!reset_n_in) && !reset_n_in
    |-> taps_out.ch1 == 256'h1 && taps_out.ch2 == 256'h1) else $error("taps not at zero in reset");
  taps_ch1_a: assert property (armed |-> taps_out.ch1 == (256'h1 << wiper_ch1_out))
    else $error("channel 1 tap wrong");
  taps_ch2_a: assert property (armed |-> taps_out.ch2 == (256'h1 << wiper_ch2_out))
    else $error("channel 2 tap wrong");
  ch1_exec_a: assert property ($past(reset_n_in, 4) && $changed(wiper_ch1_out) |-> soon_after_cs)
    else $error("channel 1 moved outside execution");
  ch2_exec_a: assert property ($past(reset_n_in, 4) && $changed(wiper_ch2_out) |-> soon_after_cs)
    else $error("channel 2 moved outside execution");
  mode_set_a: assert property ($rose(read_mode_out) |-> soon_after_cs)
    else $error("read mode set outside execution");
  mode_clr_a: assert property ($fell(read_mode_out) |-> soon_after_cs)
    else $error("read mode cleared outside execution");
endmodule
bind wcnm_core wcnm_core_monitor wcnm_core_monitor_i (.clk_in(clk_in), .reset_n_in(reset_n_in),
  .link_cs_n_in(link_cs_n_in), .taps_out(taps_out), .end_switch_a_out(end_switch_a_out),
  .end_switch_b_out(end_switch_b_out), .read_mode_out(read_mode_out),
  .wiper_ch1_out(wiper_ch1_out), .wiper_ch2_out(wiper_ch2_out));

// file: verif/wcnm_mcu_model.sv
// Controller model that sends serial frames
`timescale 1ns/100ps
module wcnm_mcu_model (
  output logic sclk_out,
  output logic cs_n_out,
  output logic sdi_out,
  input wire logic sdo_in
);
  // Idle: clock still, select high
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    sdi_out = 1'b0;
  end
  // One full 16-bit frame, MSB first; select rise executes
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    // Edges with select high carry a pending readback into the link side
    repeat (3) begin
      #3 sclk_out = 1'b1;
      #3 sclk_out = 1'b0;
    end
    #3 sclk_out = 1'b1;
    #3 cs_n_out = 1'b0;
    #3 sclk_out = 1'b0; // Falling edge puts the first bit out
    for (int i = 15; i >= 0; i--) begin
      sdi_out = tx[i];
      #3 sclk_out = 1'b1;
      rx[i] = sdo_in;
      #3 sclk_out = 1'b0;
    end
    #3 cs_n_out = 1'b1;
    sdi_out = ~tx[0];
  endtask
endmodule

// file: verif/wcnm_core_tb_top.sv
// Testbench for the wiper code core
`timescale 1ns/100ps
module wcnm_core_tb_top
  import wcnm_pkg::*;
;
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic sclk, cs_n, sdi, sdo, mode, end_a, end_b;
  logic [7:0] w1, w2;
  wcnm_taps_t taps;
  logic [15:0] rx_word; // Reply of the last frame
  int err_count = 0;
  int checked = 0;
  // Reads and expected bytes
  logic [15:0] rd [5] = '{16'h9000, 16'h9100, 16'h9200, 16'h9F00, 16'hA100};
  logic [7:0] rd_exp [5] = '{8'h40, 8'h81, 8'hA5, 8'h5A, 8'h81};
  // Shift cases: op, start code, result
  logic [19:0] sh [13] = '{20'h40000, 20'h48140, 20'h44221, 20'hC0001, 20'hC80FF,
    20'hC2142, 20'hC7FFE, 20'h58442, 20'hD90FF, 20'hE4041, 20'h60000, 20'hFFFFF, 20'h74140};
  wcnm_core wcnm_core_i (.clk_in(clk_in), .reset_n_in(reset_n_in), .clk_en_in(1'b1),
    .link_sclk_in(sclk), .link_cs_n_in(cs_n), .link_sdi_in(sdi), .link_sdo_out(sdo),
    .taps_out(taps), .end_switch_a_out(end_a), .end_switch_b_out(end_b),
    .read_mode_out(mode), .wiper_ch1_out(w1), .wiper_ch2_out(w2));
  wcnm_mcu_model wcnm_mcu_model_i (.sclk_out(sclk), .cs_n_out(cs_n), .sdi_out(sdi), .sdo_in(sdo));
  initial forever #2.5 clk_in = ~clk_in;
  task automatic fail(input string msg);
    err_count++;
    $display("ERROR %0t: %s", $time, msg);
  endtask
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) fail($sformatf("byte %h expected %h", got, exp));
  endtask
  task automatic cmp_tap(input logic [255:0] got, input logic [7:0] code);
    checked++;
    if (got !== (256'h1 << code)) fail($sformatf("tap not at %h", code));
  endtask
  task automatic cmp1(input logic got, input logic exp);
    checked++;
    if (got !== exp) fail($sformatf("flag %b expected %b", got, exp));
  endtask
  // Frame, then let execution settle
  task automatic frame(input logic [15:0] tx);
    @(posedge clk_in) #1;
    wcnm_mcu_model_i.xfer(tx, rx_word);
    repeat (10) @(posedge clk_in);
    #1;
  endtask
  task automatic summarize();
    $display("checked %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #60000;
    fail("watchdog");
    summarize();
  end
  initial begin
    repeat (4) @(posedge clk_in);
    #1 reset_n_in = 1'b1;
    repeat (6) @(posedge clk_in);
    frame(16'h0000);
    frame(16'hB040);
    frame(16'hB181);
    cmp8(rx_word[15:8], 8'hB0);
    cmp8(rx_word[7:0], 8'h40);
    cmp8(w1, 8'h40);
    cmp8(w2, 8'h81);
    cmp_tap(taps.ch1, 8'h40);
    cmp1(end_a & end_b, 1'b1);
    $display("wiper write test done");
    frame(16'h2000);
    frame(16'h2100);
    frame(16'hB0FF);
    frame(16'hB100);
    cmp_tap(taps.ch1, 8'hFF);
    cmp_tap(taps.ch2, 8'h00);
    frame(16'h8000);
    cmp8(w1, 8'h40);
    cmp8(w2, 8'h81);
    frame(16'hB000);
    frame(16'h1000);
    cmp8(w1, 8'h40);
    cmp1(mode, 1'b1);
    frame(16'h0000);
    cmp1(mode, 1'b0);
    $display("restore test done");
    frame(16'h32A5);
    frame(16'h3F5A);
    for (int i = 0; i < 5; i++) begin
      frame(rd[i]);
      frame(16'h0000);
      cmp8(rx_word[7:0], rd_exp[i]);
      cmp8(rx_word[15:8], 8'h00);
    end
    $display("readback test done");
    for (int i = 0; i < 13; i++) begin
      frame({8'hB0, sh[i][15:8]});
      frame({sh[i][19:16], 12'h000});
      cmp8(w1, sh[i][7:0]);
    end
    $display("shift test done");
    summarize();
  end
endmodule
